// ### bench/fldrv_host_model.sv
// two-wire bus master model that drives the configuration bank
// assumes the bench forms the data line from both enables with a pull-up
`timescale 1ns/100ps
module fldrv_host_model (
	input wire logic core_clk,
	input wire logic sdaLine,
	output logic scl,
	output logic sdaDrv
);
	import fldrv_pkg::*;
	// half period kept well above the slave's pin sync delay
	localparam int HALF = 10;
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic hp();
		repeat (HALF) @(negedge core_clk);
	endtask : hp
	// data never moves with the clock fall, or it could read as start
	task automatic hold();
		repeat (3) @(negedge core_clk);
	endtask : hold
	task automatic sendBit(input logic b);
		hold();
		sdaDrv = b;
		hp();
		scl = 1'b1;
		hp();
		scl = 1'b0;
	endtask : sendBit
	task automatic takeBit(output logic b);
		hold();
		sdaDrv = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		b = sdaLine;
		scl = 1'b0;
	endtask : takeBit
	task automatic startCond();
		hold();
		sdaDrv = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sdaDrv = 1'b0;
		hp();
		scl = 1'b0;
	endtask : startCond
	task automatic stopCond();
		hold();
		sdaDrv = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sdaDrv = 1'b1;
		hp();
	endtask : stopCond
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) sendBit(d[i]);
		takeBit(b);
		ack = ~b;
	endtask : sendByte
	task automatic takeByte(input logic ackIt, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) takeBit(d[i]);
		sendBit(~ackIt);
	endtask : takeByte
	task automatic wrReg(input logic [7:0] addr, input logic [7:0] sub,
		input logic [7:0] data, output logic [2:0] acks);
		startCond();
		sendByte(addr, acks[2]);
		sendByte(sub, acks[1]);
		sendByte(data, acks[0]);
		stopCond();
	endtask : wrReg
	task automatic rdReg(input logic [7:0] sub, output logic [7:0] d,
		output logic [2:0] acks);
		startCond();
		// write address, subaddress, restart, read address
		sendByte(8'h60, acks[2]);
		sendByte(sub, acks[1]);
		startCond();
		sendByte(8'h61, acks[0]);
		takeByte(1'b0, d);
		stopCond();
	endtask : rdReg
endmodule : fldrv_host_model

// ### bench/tb_top.sv
// self-checking bench for the flash driver configuration bank
// assumes fldrv_regs and fldrv_host_model are compiled before it
`timescale 1ns/100ps
module tb_top;
	import fldrv_pkg::*;
	// short timer step keeps timeout runs brief
	localparam int STEP = 10;
	// arbitrary information byte, not a real part code
	localparam logic [7:0] INFO = 8'h3C;
	localparam logic [23:0] DEFS = 24'h0F73A4;
	typedef struct {
		logic [7:0] sub;
		logic [7:0] wdat;
		logic [7:0] rexp;
	} fldrv_row_t;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic strobePin = 1'b0;
	logic enablePin = 1'b1;
	logic critFault = 1'b0;
	logic faultClear = 1'b0;
	logic scl;
	logic hostSda;
	logic sdaLine;
	logic sdaOut;
	logic sdaOeB;
	logic flashFire;
	logic timeoutFault;
	fldrv_cfg_t cfg;
	int mismatches = 0;
	int checkCount = 0;
	int fireCount = 0;
	int f0;
	logic [2:0] acks;
	logic [7:0] rd;
	logic [23:0] prev;
	fldrv_row_t rows [13] = '{
		'{8'h00, 8'hFF, INFO}, '{8'h01, 8'hFF, 8'h00},
		'{8'h05, 8'hFF, 8'h00}, '{8'h02, 8'h00, 8'h00},
		'{8'h02, 8'h50, 8'h50}, '{8'h02, 8'hA5, 8'hA5},
		'{8'h02, 8'hFF, 8'hFF}, '{8'h03, 8'hC7, 8'hC7},
		'{8'h03, 8'h00, 8'h00}, '{8'h04, 8'h40, 8'h40},
		'{8'h04, 8'h55, 8'h55}, '{8'h04, 8'hF2, 8'hF2},
		'{8'h04, 8'h37, 8'h37}
	};
	always #5 core_clk = ~core_clk;
	assign sdaLine = hostSda & (sdaOeB | sdaOut);
	always @(posedge core_clk) begin
		if (flashFire === 1'b1)
			fireCount <= fireCount + 1;
	end
	fldrv_regs #(.STEP_CYC(STEP), .DESIGN_INFO(INFO)) DUT (
		.core_clk(core_clk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOeB(sdaOeB), .strobePin(strobePin),
		.enablePin(enablePin), .critFault(critFault),
		.faultClear(faultClear), .cfg(cfg), .flashFire(flashFire),
		.timeoutFault(timeoutFault)
	);
	fldrv_host_model host (
		.core_clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(hostSda)
	);
	task automatic chk(input logic [23:0] got, input logic [23:0] exp,
		input string what);
		checkCount++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic resetDut();
		@(negedge core_clk);
		rst_b = 1'b0;
		repeat (12) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (8) @(negedge core_clk);
	endtask : resetDut
	task automatic checkDefaults();
		chk(cfg, DEFS, "reset cfg");
		chk(24'(sdaOeB), 24'h1, "line released");
		chk(24'({flashFire, timeoutFault}), 24'h0, "outputs idle");
	endtask : checkDefaults
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (90000) @(posedge core_clk);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		resetDut();
		checkDefaults();
		for (int i = 0; i < 3; i++) begin
			host.rdReg(8'(i + 2), rd, acks);
			chk(24'(rd), 24'(DEFS[8 * (2 - i) +: 8]), "default");
		end
		$display("test reset done");
		foreach (rows[i]) begin
			prev = cfg;
			host.wrReg(8'h60, rows[i].sub, rows[i].wdat, acks);
			chk(24'(acks), 24'h7, "write acks");
			host.rdReg(rows[i].sub, rd, acks);
			chk(24'(rd), 24'(rows[i].rexp), "readback");
			if (rows[i].sub inside {8'h02, 8'h03, 8'h04})
				chk(24'(cfg[8 * (4 - rows[i].sub) +: 8]),
					24'(rows[i].rexp), "cfg field");
			else
				chk(24'(cfg), prev, "cfg kept");
		end
		$display("test table done");
		host.wrReg(8'h62, 8'h03, 8'hFF, acks);
		chk(24'(acks), 24'h0, "foreign address");
		chk(24'(cfg.cur), 24'h0, "foreign write");
		host.wrReg(8'h60, 8'h04, 8'h03, acks);
		f0 = fireCount;
		host.wrReg(8'h60, 8'h04, 8'h0B, acks);
		chk(24'(fireCount - f0), 24'h1, "software fire");
		@(negedge core_clk);
		critFault = 1'b1;
		@(negedge core_clk);
		critFault = 1'b0;
		chk(24'(cfg.mode.outputEnable), 24'h0, "fault off");
		$display("test software flash done");
		host.wrReg(8'h60, 8'h02, 8'h01, acks);
		host.wrReg(8'h60, 8'h04, 8'h2F, acks);
		f0 = fireCount;
		strobePin = 1'b1;
		repeat (2 * STEP) @(negedge core_clk);
		chk(24'(fireCount - f0), 24'h1, "strobe fire");
		chk(24'(timeoutFault), 24'h0, "early timeout");
		repeat (STEP) @(negedge core_clk);
		chk(24'(timeoutFault), 24'h1, "timeout");
		chk(24'(cfg.mode.outputEnable), 24'h0, "timeout off");
		strobePin = 1'b0;
		faultClear = 1'b1;
		@(negedge core_clk);
		faultClear = 1'b0;
		@(negedge core_clk);
		chk(24'(timeoutFault), 24'h0, "fault clear");
		// edge sensing: one flash, no timeout however long the strobe
		host.wrReg(8'h60, 8'h04, 8'h0F, acks);
		f0 = fireCount;
		strobePin = 1'b1;
		repeat (4 * STEP) @(negedge core_clk);
		chk(24'(fireCount - f0), 24'h1, "edge fire");
		chk(24'(timeoutFault), 24'h0, "edge no timeout");
		chk(24'(cfg.mode.outputEnable), 24'h1, "edge stays on");
		strobePin = 1'b0;
		$display("test hardware flash done");
		enablePin = 1'b0;
		repeat (10) @(negedge core_clk);
		enablePin = 1'b1;
		repeat (10) @(negedge core_clk);
		chk(24'(cfg), DEFS, "enable rise");
		host.wrReg(8'h60, 8'h03, 8'h00, acks);
		resetDut();
		checkDefaults();
		$display("test enable and reset done");
		tally_and_finish();
	end
endmodule : tb_top

// ### rtl/fldrv_cfg.svh
// offsets, reset values, bus addresses and timing of the flash driver
// configuration bank; included by the register bank design file only
`ifndef FLDRV_CFG_SVH
`define FLDRV_CFG_SVH

`define FLD_OFS_INFO 8'h00
`define FLD_OFS_UNUSED 8'h01
`define FLD_OFS_PINTIM 8'h02
`define FLD_OFS_CUR 8'h03
`define FLD_OFS_MODE 8'h04

`define FLD_ADDR_WR 8'h60
`define FLD_ADDR_RD 8'h61

`define FLD_RST_PINTIM 8'h0F
`define FLD_RST_CUR 8'h73
`define FLD_RST_MODE 8'hA4

`define FLD_BITS_BYTE 4'h8

// flash timer step and core clock rate
`define FLD_STEP_MS 100
`define FLD_CLK_MHZ 100
`define FLD_STEP_CYC (`FLD_STEP_MS * 1000 * `FLD_CLK_MHZ)

`endif

// ### rtl/fldrv_pkg.sv
// types of the flash driver configuration bank
// uses none of the macros in fldrv_cfg.svh
package fldrv_pkg;

	typedef enum logic [1:0] {
		FLDRV_P2_HIZ = 2'h0,
		FLDRV_P2_IND = 2'h1,
		FLDRV_P2_TXM = 2'h2,
		FLDRV_P2_ADC = 2'h3
	} fldrv_p2fn_t;

	typedef enum logic [1:0] {
		FLDRV_P1_HIZ = 2'h0,
		FLDRV_P1_TORCH = 2'h1,
		FLDRV_P1_TXM = 2'h2,
		FLDRV_P1_RSVD = 2'h3
	} fldrv_p1fn_t;

	typedef enum logic [1:0] {
		FLDRV_STANDBY = 2'h0,
		FLDRV_BOOST5 = 2'h1,
		FLDRV_ASSIST = 2'h2,
		FLDRV_FLASH = 2'h3
	} fldrv_led_t;

	typedef struct packed {
		fldrv_p2fn_t pinTwoFunctionSelect;
		fldrv_p1fn_t pinOneFunctionSelect;
		logic [3:0] flashDurationCode;
	} fldrv_pintim_t;

	typedef struct packed {
		logic [4:0] flashCurrentCode;
		logic [2:0] torchCurrentCode;
	} fldrv_cur_t;

	typedef struct packed {
		logic [1:0] peakCurrentLimitCode;
		logic strobeLevelSense;
		logic switchingFoldbackAllow;
		logic outputEnable;
		logic strobeSourceSelect;
		fldrv_led_t ledOperatingSelect;
	} fldrv_mode_t;

	typedef struct packed {
		fldrv_pintim_t pinTim;
		fldrv_cur_t cur;
		fldrv_mode_t mode;
	} fldrv_cfg_t;

	typedef enum logic [8:0] {
		FLDRV_IDLE = 9'h001,
		FLDRV_ADDR = 9'h002,
		FLDRV_AACK = 9'h004,
		FLDRV_SUB = 9'h008,
		FLDRV_SACK = 9'h010,
		FLDRV_WDAT = 9'h020,
		FLDRV_WACK = 9'h040,
		FLDRV_RDAT = 9'h080,
		FLDRV_MACK = 9'h100
	} fldrv_st_t;

endpackage : fldrv_pkg

// ### rtl/fldrv_regs.sv
// flash driver configuration bank behind a two-wire serial slave
// assumes scl, sda, strobe and enable pins are asynchronous;
// critFault and faultClear come from logic on core_clk
`timescale 1ns/100ps
`include "fldrv_cfg.svh"

// Operation
// - read-only information byte at offset zero
// - bit seven is msb, sent first
// - pin two function select field
// - pin one function select field
// - flash duration is code plus one steps
// - flash current code field
// - torch current code field
// - peak current limit field, default two
// - strobe level or edge sensing bit
// - switching foldback allow bit
// - output enable bit, default off
// - software strobe fires on enable in flash
// - led operating select field
// - answers address 0x60 write, 0x61 read
// - critical fault clears output enable
// - enable pin rise restores all defaults
// - level strobe beyond timer flags timeout
module fldrv_regs #(
	parameter int STEP_CYC = `FLD_STEP_CYC,
	// arbitrary value, not a real part code
	parameter logic [7:0] DESIGN_INFO = 8'h5A
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeB,
	input wire logic strobePin,
	input wire logic enablePin,
	input wire logic critFault,
	input wire logic faultClear,
	output fldrv_pkg::fldrv_cfg_t cfg,
	output logic flashFire,
	output logic timeoutFault
);
	import fldrv_pkg::*;

	logic sclS, sdaS, strbS, enS;
	logic sclP_q, sdaP_q, enP_q, strbP_q, enPrev_q;
	fldrv_st_t st_q, st_d;
	logic [3:0] bc_q, bc_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] ptr_q, ptr_d;
	logic drvB_q, drvB_d, rw_q, rw_d, mack_q, mack_d;
	fldrv_pintim_t pt_q, pt_d;
	fldrv_cur_t cu_q, cu_d;
	fldrv_mode_t md_q, md_d;
	logic [7:0] rdByte;
	logic wrHit, sclR, sclF, startC, stopC, enRise;
	logic [31:0] cnt_q, cnt_d;
	logic [3:0] idx_q, idx_d;
	logic tmoAct, tmoHit, fire_q, fire_d, tmo_q, tmo_d;

	fldrv_sync uSyncScl (.core_clk(core_clk), .rst_b(rst_b),
		.din(scl), .dout(sclS));
	fldrv_sync uSyncSda (.core_clk(core_clk), .rst_b(rst_b),
		.din(sdaIn), .dout(sdaS));
	fldrv_sync uSyncStrb (.core_clk(core_clk), .rst_b(rst_b),
		.din(strobePin), .dout(strbS));
	fldrv_sync uSyncEn (.core_clk(core_clk), .rst_b(rst_b),
		.din(enablePin), .dout(enS));

	assign sclR = sclS & ~sclP_q;
	assign sclF = ~sclS & sclP_q;
	assign startC = sclS & sclP_q & sdaP_q & ~sdaS;
	assign stopC = sclS & sclP_q & ~sdaP_q & sdaS;
	assign enRise = enS & ~enP_q;

	always_comb begin
		case (ptr_q)
			`FLD_OFS_INFO: rdByte = DESIGN_INFO;
			`FLD_OFS_PINTIM: rdByte = pt_q;
			`FLD_OFS_CUR: rdByte = cu_q;
			`FLD_OFS_MODE: rdByte = md_q;
			default: rdByte = 8'h00;
		endcase
	end

	always_comb begin
		st_d = st_q;
		bc_d = bc_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		drvB_d = drvB_q;
		rw_d = rw_q;
		mack_d = mack_q;
		pt_d = pt_q;
		cu_d = cu_q;
		md_d = md_q;
		wrHit = 1'b0;
		if (startC) begin
			st_d = FLDRV_ADDR;
			bc_d = 4'h0;
			drvB_d = 1'b1;
		end else if (stopC) begin
			st_d = FLDRV_IDLE;
			drvB_d = 1'b1;
		end else begin
			case (st_q)
				FLDRV_IDLE: begin
					drvB_d = 1'b1;
				end
				FLDRV_ADDR, FLDRV_SUB, FLDRV_WDAT: begin
					if (sclR) begin
						sh_d = {sh_q[6:0], sdaS};
						bc_d = bc_q + 4'h1;
					end else if (sclF && bc_q == `FLD_BITS_BYTE) begin
						bc_d = 4'h0;
						if (st_q == FLDRV_ADDR) begin
							if (sh_q == `FLD_ADDR_WR || sh_q == `FLD_ADDR_RD) begin
								st_d = FLDRV_AACK;
								drvB_d = 1'b0;
								rw_d = sh_q[0];
							end else begin
								st_d = FLDRV_IDLE;
							end
						end else if (st_q == FLDRV_SUB) begin
							ptr_d = sh_q;
							st_d = FLDRV_SACK;
							drvB_d = 1'b0;
						end else begin
							wrHit = 1'b1;
							st_d = FLDRV_WACK;
							drvB_d = 1'b0;
						end
					end
				end
				FLDRV_AACK, FLDRV_SACK, FLDRV_WACK: begin
					if (sclF) begin
						drvB_d = 1'b1;
						if (st_q == FLDRV_AACK && rw_q) begin
							st_d = FLDRV_RDAT;
							sh_d = {rdByte[6:0], 1'b0};
							drvB_d = rdByte[7];
						end else if (st_q == FLDRV_AACK) begin
							st_d = FLDRV_SUB;
						end else if (st_q == FLDRV_SACK) begin
							st_d = FLDRV_WDAT;
						end else begin
							// one register per transfer
							st_d = FLDRV_IDLE;
						end
					end
				end
				FLDRV_RDAT: begin
					if (sclR) begin
						bc_d = bc_q + 4'h1;
					end else if (sclF) begin
						if (bc_q == `FLD_BITS_BYTE) begin
							st_d = FLDRV_MACK;
							drvB_d = 1'b1;
							bc_d = 4'h0;
						end else begin
							drvB_d = sh_q[7];
							sh_d = {sh_q[6:0], 1'b0};
						end
					end
				end
				FLDRV_MACK: begin
					if (sclR) begin
						mack_d = ~sdaS;
					end else if (sclF) begin
						// an acked read repeats the same register
						if (mack_q) begin
							st_d = FLDRV_RDAT;
							sh_d = {rdByte[6:0], 1'b0};
							drvB_d = rdByte[7];
						end else begin
							st_d = FLDRV_IDLE;
						end
					end
				end
				default: begin
					st_d = FLDRV_IDLE;
					drvB_d = 1'b1;
				end
			endcase
		end
		if (wrHit) begin
			case (ptr_q)
				`FLD_OFS_PINTIM: pt_d = fldrv_pintim_t'(sh_q);
				`FLD_OFS_CUR: cu_d = fldrv_cur_t'(sh_q);
				`FLD_OFS_MODE: md_d = fldrv_mode_t'(sh_q);
				default: begin
				end
			endcase
		end
		if (critFault || tmoHit) begin
			md_d.outputEnable = 1'b0;
		end
		if (enRise) begin
			pt_d = fldrv_pintim_t'(`FLD_RST_PINTIM);
			cu_d = fldrv_cur_t'(`FLD_RST_CUR);
			md_d = fldrv_mode_t'(`FLD_RST_MODE);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_q <= FLDRV_IDLE;
			bc_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			drvB_q <= 1'b1;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			pt_q <= fldrv_pintim_t'(`FLD_RST_PINTIM);
			cu_q <= fldrv_cur_t'(`FLD_RST_CUR);
			md_q <= fldrv_mode_t'(`FLD_RST_MODE);
			sclP_q <= 1'b1;
			sdaP_q <= 1'b1;
			enP_q <= 1'b1;
		end else begin
			st_q <= st_d;
			bc_q <= bc_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			drvB_q <= drvB_d;
			rw_q <= rw_d;
			mack_q <= mack_d;
			pt_q <= pt_d;
			cu_q <= cu_d;
			md_q <= md_d;
			sclP_q <= sclS;
			sdaP_q <= sdaS;
			enP_q <= enS;
		end
	end

	// level strobe from host, timeout only when level sensed
	assign tmoAct = md_q.strobeSourceSelect & md_q.strobeLevelSense &
		md_q.outputEnable & strbS;
	assign tmoHit = tmoAct && idx_q == pt_q.flashDurationCode &&
		cnt_q == 32'(STEP_CYC - 1);

	always_comb begin
		cnt_d = 32'h0;
		idx_d = 4'h0;
		if (tmoAct && cnt_q == 32'(STEP_CYC - 1)) begin
			idx_d = idx_q + 4'h1;
		end else if (tmoAct) begin
			cnt_d = cnt_q + 32'h1;
			idx_d = idx_q;
		end
		fire_d = md_q.ledOperatingSelect == FLDRV_FLASH &&
			md_q.outputEnable &&
			((!md_q.strobeSourceSelect && !enPrev_q) ||
			(md_q.strobeSourceSelect && strbS && !strbP_q));
		tmo_d = tmoHit | (tmo_q & ~faultClear);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cnt_q <= 32'h0;
			idx_q <= 4'h0;
			fire_q <= 1'b0;
			tmo_q <= 1'b0;
			enPrev_q <= 1'b0;
			strbP_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			fire_q <= fire_d;
			tmo_q <= tmo_d;
			enPrev_q <= md_q.outputEnable;
			strbP_q <= strbS;
		end
	end

	// open drain: only ever pulls low
	assign sdaOut = 1'b0;
	assign sdaOeB = drvB_q;
	assign cfg = {pt_q, cu_q, md_q};
	assign flashFire = fire_q;
	assign timeoutFault = tmo_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	info_read_a: assert property (ptr_q == `FLD_OFS_INFO |->
		rdByte == DESIGN_INFO) else $error("info byte wrong");
	unused_zero_a: assert property (ptr_q == `FLD_OFS_UNUSED |->
		rdByte == 8'h00) else $error("offset one not zero");
	info_write_a: assert property (wrHit &&
		ptr_q == `FLD_OFS_INFO && !enRise && !critFault && !tmoHit
		|=> $stable(cfg)) else $error("info write changed bank");
	cur_write_a: assert property (wrHit &&
		ptr_q == `FLD_OFS_CUR && !enRise |=> cu_q == $past(sh_q))
		else $error("current write lost");
	fault_off_a: assert property (critFault |=>
		!md_q.outputEnable) else $error("fault left output on");
	en_default_a: assert property (enRise |=>
		cfg == {`FLD_RST_PINTIM, `FLD_RST_CUR, `FLD_RST_MODE})
		else $error("enable rise missed defaults");
	sw_fire_a: assert property ($rose(md_q.outputEnable) &&
		!md_q.strobeSourceSelect &&
		md_q.ledOperatingSelect == FLDRV_FLASH |=> fire_q)
		else $error("software flash missing");
	timeout_a: assert property (tmoHit |=>
		tmo_q && !md_q.outputEnable) else $error("timeout not flagged");
	addr_nack_a: assert property (st_q == FLDRV_ADDR && sclF &&
		!startC && !stopC && bc_q == `FLD_BITS_BYTE &&
		sh_q[7:1] != `FLD_ADDR_WR >> 1 |=> st_q == FLDRV_IDLE && drvB_q)
		else $error("foreign address acked");

	wr_c: cover property (wrHit && ptr_q == `FLD_OFS_MODE);
	rd_c: cover property (st_q == FLDRV_RDAT && sclF);
	fire_c: cover property (fire_q);
	tmo_c: cover property (tmoHit);
endmodule : fldrv_regs

// ### rtl/fldrv_sync.sv
// three-flop input synchroniser with agreement filter
// assumes din is asynchronous to core_clk
`timescale 1ns/100ps
module fldrv_sync (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic din,
	output logic dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;
	logic out_d;

	// only a change seen by both later stages counts
	always_comb begin
		out_d = (s2_q == s3_q) ? s3_q : out_q;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			out_q <= 1'b1;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end

	assign dout = out_q;
endmodule : fldrv_sync
